// ### hdl/ccse_params.svh
`ifndef CCSE_PARAMS_SVH
`define CCSE_PARAMS_SVH

// Opcode fields of the two executed instructions.
`define CCSE_COMP_OPC       6'h07
`define CCSE_CPSEQ_OPC      7'h31
`define CCSE_DEST_BIT       9
`define CCSE_BANK_BIT       8

// Access bank split and the extended-mode indexed window (f <= 95).
`define CCSE_ACCESS_SPLIT   8'h60
`define CCSE_INDEXED_MAX    8'h5f
`define CCSE_ACCESS_HI_BANK 4'hf

// Quarter cycles per instruction cycle.
`define CCSE_QUARTERS       3'h4

// Register offsets (byte addresses).
`define CCSE_REG_CTRL       4'h0
`define CCSE_REG_BANK       4'h4
`define CCSE_REG_ACC        4'h8
`define CCSE_REG_STATUS     4'hc
`define CCSE_ADDR_BITS      4

// Field positions.
`define CCSE_CTRL_EXT       0
`define CCSE_ST_ZERO        0
`define CCSE_ST_NEG         1
`define CCSE_ST_SKIP        2
`define CCSE_ST_BADOP       3
`define CCSE_ST_BUSY        4
`define CCSE_IDX_LSB        8

// Reset values.
`define CCSE_RST_ACC        8'h00
`define CCSE_RST_BANK       4'h0
`define CCSE_RST_INDEX      12'h000

// AXI responses.
`define CCSE_RESP_OKAY      2'h0
`define CCSE_RESP_SLVERR    2'h2

`endif

// ### hdl/ccse_pkg.sv
`include "ccse_params.svh"

package ccse_pkg;

  // Gray codes along decode, read, process, write.
  typedef enum logic [2:0] {
    CCSE_IDLE = 3'h0,
    CCSE_DEC  = 3'h1,
    CCSE_RD   = 3'h3,
    CCSE_PROC = 3'h2,
    CCSE_WR   = 3'h6,
    CCSE_NOP  = 3'h7
  } ccse_state_t;

  typedef enum logic [1:0] {
    CCSE_OP_NONE  = 2'h0,
    CCSE_OP_COMP  = 2'h1,
    CCSE_OP_CPSEQ = 2'h2
  } ccse_op_t;

  function automatic ccse_op_t ccse_decode(input logic [15:0] word);
    if (word[15:10] == `CCSE_COMP_OPC) begin
      return CCSE_OP_COMP;
    end else if (word[15:9] == `CCSE_CPSEQ_OPC) begin
      return CCSE_OP_CPSEQ;
    end
    return CCSE_OP_NONE;
  endfunction : ccse_decode

  function automatic logic [11:0] ccse_data_addr(
    input logic        bankBit,
    input logic [7:0]  fileAddr,
    input logic [3:0]  bankSel,
    input logic        extEnable,
    input logic [11:0] indexBase
  );
    if (bankBit) begin
      return {bankSel, fileAddr};
    end else if (extEnable && fileAddr <= `CCSE_INDEXED_MAX) begin
      return indexBase + {4'h0, fileAddr};
    end else if (fileAddr < `CCSE_ACCESS_SPLIT) begin
      return {4'h0, fileAddr};
    end
    return {`CCSE_ACCESS_HI_BANK, fileAddr};
  endfunction : ccse_data_addr

endpackage : ccse_pkg

// ### hdl/ccse_alu_if.sv
interface ccse_alu_if;
  ccse_pkg::ccse_op_t op;
  logic [7:0]         operand;
  logic [7:0]         acc;
  logic [7:0]         result;
  logic               equal;
  logic               neg;
  logic               zero;

  modport core (output op, operand, acc, input result, equal, neg, zero);
  modport alu  (input op, operand, acc, output result, equal, neg, zero);
endinterface : ccse_alu_if

// ### hdl/ccse_alu.sv
module ccse_alu (
  ccse_alu_if.alu bus
);

  logic [7:0] diff;

  // Equality only means something for the compare; it drives the skip.
  always_comb begin
    diff       = bus.operand - bus.acc;
    bus.equal  = (bus.op == ccse_pkg::CCSE_OP_CPSEQ) &&
                 (diff == 8'h00); // RL6
    bus.result = ~bus.operand; // RL1
    bus.neg    = bus.result[7];
    bus.zero   = (bus.result == 8'h00);
  end

endmodule : ccse_alu

// ### hdl/ccse_exec.sv
// Overview of operation
// RL1: Decode complement opcode 000111da plus address; produce the inverted byte.
// RL2: Complement destination bit zero writes accumulator, one writes memory byte.
// RL3: Cleared bank bit addresses the access bank, not the bank select register.
// RL4: Set bank bit forms the address from bank select register and file address.
// RL5: Extended set, bank bit zero, address up to 95 uses indexed offset.
// RL6: Decode compare opcode 0110001a; unsigned subtract against accumulator, no store.
// RL7: On equality discard the fetched instruction and run one no-operation cycle.
// RL8: Skipping a two-word instruction inserts two no-operation cycles, three total.
// RL9: Complement updates negative and zero flags; compare leaves flags alone.
// RL10: Complement is one word, one cycle: decode, read, compute, write quarters.
//
// Local design decisions: the register offsets and the AXI4-Lite slave port.
`include "ccse_params.svh"

module ccse_exec (
  input  wire logic        ref_clk,
  input  wire logic        rstn,
  input  wire logic [15:0] instrWord,
  input  wire logic        instrValid,
  output logic             instrReady,
  input  wire logic        nextTwoWord,
  output logic             flushNext,
  output logic             instrDone,
  output logic [11:0]      memAddr,
  output logic             memRdEn,
  input  wire logic [7:0]  memRdData,
  output logic             memWrEn,
  output logic [7:0]       memWrData,
  input  wire logic [3:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [3:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);

  ccse_pkg::ccse_state_t state;
  ccse_pkg::ccse_op_t    op;
  logic [15:0]           instr;
  logic [7:0]            operand;
  logic [7:0]            acc;
  logic [3:0]            bankSel;
  logic [11:0]           indexBase;
  logic                  extEnable;
  logic                  zeroFlag;
  logic                  negFlag;
  logic                  lastSkip;
  logic                  badOp;
  logic [2:0]            quarter;
  logic [1:0]            nopCycles;
  logic                  awHeld;
  logic                  wHeld;
  logic [3:0]            awAddr;
  logic [31:0]           wData;
  logic [3:0]            wStrb;
  logic                  swWrite;
  logic                  accWrite;
  logic                  flagWrite;

  ccse_alu_if aluBus ();

  ccse_alu u_alu (
    .bus (aluBus)
  );

  assign aluBus.op      = op;
  assign aluBus.operand = operand;
  assign aluBus.acc     = acc;

  assign instrReady = (state == ccse_pkg::CCSE_IDLE);

  // Instruction sequencing, one quarter cycle per clock.
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      state     <= ccse_pkg::CCSE_IDLE;
      op        <= ccse_pkg::CCSE_OP_NONE;
      instr     <= 16'h0000;
      quarter   <= 3'h0;
      nopCycles <= 2'h0;
    end else begin
      unique case (state)
        ccse_pkg::CCSE_IDLE: begin
          if (instrValid) begin
            instr <= instrWord;
            op    <= ccse_pkg::ccse_decode(instrWord); // RL1 RL6
            if (ccse_pkg::ccse_decode(instrWord) !=
                ccse_pkg::CCSE_OP_NONE) begin
              state <= ccse_pkg::CCSE_DEC;
            end
          end
        end
        ccse_pkg::CCSE_DEC:  state <= ccse_pkg::CCSE_RD; // RL10
        ccse_pkg::CCSE_RD:   state <= ccse_pkg::CCSE_PROC;
        ccse_pkg::CCSE_PROC: state <= ccse_pkg::CCSE_WR;
        ccse_pkg::CCSE_WR: begin
          if (op == ccse_pkg::CCSE_OP_CPSEQ && aluBus.equal) begin
            state     <= ccse_pkg::CCSE_NOP; // RL7
            nopCycles <= nextTwoWord ? 2'h2 : 2'h1; // RL8
            quarter   <= 3'h1;
          end else begin
            state <= ccse_pkg::CCSE_IDLE;
          end
        end
        ccse_pkg::CCSE_NOP: begin
          if (quarter == `CCSE_QUARTERS) begin
            quarter <= 3'h1;
            if (nopCycles == 2'h1) begin
              state <= ccse_pkg::CCSE_IDLE;
            end
            nopCycles <= nopCycles - 2'h1;
          end else begin
            quarter <= quarter + 3'h1;
          end
        end
        default: state <= ccse_pkg::CCSE_IDLE;
      endcase
    end
  end

  // Data memory read and write-back.
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      memAddr   <= 12'h000;
      memRdEn   <= 1'b0;
      memWrEn   <= 1'b0;
      memWrData <= 8'h00;
      operand   <= 8'h00;
    end else begin
      memRdEn <= (state == ccse_pkg::CCSE_DEC);
      memWrEn <= 1'b0;
      if (state == ccse_pkg::CCSE_DEC) begin
        memAddr <= ccse_pkg::ccse_data_addr(instr[`CCSE_BANK_BIT],
                     instr[7:0], bankSel, extEnable, indexBase); // RL3 RL4 RL5
      end
      if (state == ccse_pkg::CCSE_PROC) begin
        operand <= memRdData;
      end
      if (state == ccse_pkg::CCSE_WR && op == ccse_pkg::CCSE_OP_COMP &&
          instr[`CCSE_DEST_BIT]) begin
        memWrEn   <= 1'b1; // RL2
        memWrData <= aluBus.result;
      end
    end
  end

  // Pipeline strobes: the flush tells fetch to drop the prefetched word.
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      flushNext <= 1'b0;
      instrDone <= 1'b0;
    end else begin
      flushNext <= state == ccse_pkg::CCSE_WR &&
                   op == ccse_pkg::CCSE_OP_CPSEQ && aluBus.equal; // RL7
      instrDone <= (state == ccse_pkg::CCSE_WR &&
                    !(op == ccse_pkg::CCSE_OP_CPSEQ && aluBus.equal)) ||
                   (state == ccse_pkg::CCSE_NOP &&
                    quarter == `CCSE_QUARTERS && nopCycles == 2'h1);
    end
  end

  assign swWrite  = awHeld && wHeld && !s_axi_bvalid;
  assign flagWrite = state == ccse_pkg::CCSE_WR &&
                     op == ccse_pkg::CCSE_OP_COMP;
  assign accWrite  = flagWrite && !instr[`CCSE_DEST_BIT];

  // Accumulator and flags; the core's own update beats a software write,
  // but only for what the core really changes, so a memory-destined
  // complement does not swallow a software write to the accumulator.
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      acc      <= `CCSE_RST_ACC;
      zeroFlag <= 1'b0;
      negFlag  <= 1'b0;
    end else begin
      if (accWrite) begin
        acc <= aluBus.result; // RL2
      end else if (swWrite && wStrb[0] && awAddr == `CCSE_REG_ACC) begin
        acc <= wData[7:0];
      end
      if (flagWrite) begin
        zeroFlag <= aluBus.zero; // RL9
        negFlag  <= aluBus.neg; // RL9
      end else if (swWrite && wStrb[0] && awAddr == `CCSE_REG_STATUS) begin
        zeroFlag <= wData[`CCSE_ST_ZERO];
        negFlag  <= wData[`CCSE_ST_NEG];
      end
    end
  end

  // Outcome bits: lastSkip follows each compare; badOp is sticky, and hardware setting wins over a clear.
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      lastSkip <= 1'b0;
      badOp    <= 1'b0;
    end else begin
      if (state == ccse_pkg::CCSE_WR && op == ccse_pkg::CCSE_OP_CPSEQ) begin
        lastSkip <= aluBus.equal;
      end
      if (instrReady && instrValid &&
          ccse_pkg::ccse_decode(instrWord) == ccse_pkg::CCSE_OP_NONE) begin
        badOp <= 1'b1;
      end else if (swWrite && wStrb[0] && awAddr == `CCSE_REG_STATUS &&
                   wData[`CCSE_ST_BADOP]) begin
        badOp <= 1'b0;
      end
    end
  end

  // Control registers written by software.
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      extEnable <= 1'b0;
      indexBase <= `CCSE_RST_INDEX;
      bankSel   <= `CCSE_RST_BANK;
    end else if (swWrite) begin
      if (awAddr == `CCSE_REG_CTRL) begin
        if (wStrb[0]) begin
          extEnable <= wData[`CCSE_CTRL_EXT];
        end
        if (wStrb[1]) begin
          indexBase[7:0] <= wData[`CCSE_IDX_LSB +: 8];
        end
        if (wStrb[2]) begin
          indexBase[11:8] <= wData[`CCSE_IDX_LSB + 8 +: 4];
        end
      end
      if (awAddr == `CCSE_REG_BANK && wStrb[0]) begin
        bankSel <= wData[3:0];
      end
    end
  end

  // AXI4-Lite write channel: address and data are taken in either order.
  assign s_axi_awready = !awHeld;
  assign s_axi_wready  = !wHeld;

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      awHeld       <= 1'b0;
      wHeld        <= 1'b0;
      awAddr       <= 4'h0;
      wData        <= 32'h0000_0000;
      wStrb        <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `CCSE_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && !awHeld) begin
        awHeld <= 1'b1;
        awAddr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !wHeld) begin
        wHeld <= 1'b1;
        wData <= s_axi_wdata;
        wStrb <= s_axi_wstrb;
      end
      if (swWrite) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (awAddr[1:0] == 2'h0) ? `CCSE_RESP_OKAY
                                              : `CCSE_RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        awHeld       <= 1'b0;
        wHeld        <= 1'b0;
      end
    end
  end

  // AXI4-Lite read channel; one read at a time.
  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= `CCSE_RESP_OKAY;
    end else if (s_axi_arvalid && !s_axi_rvalid) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= `CCSE_RESP_OKAY;
      s_axi_rdata  <= 32'h0000_0000;
      unique case (s_axi_araddr)
        `CCSE_REG_CTRL:   s_axi_rdata <= {12'h000, indexBase, 7'h00, extEnable};
        `CCSE_REG_BANK:   s_axi_rdata <= {28'h0000000, bankSel};
        `CCSE_REG_ACC:    s_axi_rdata <= {24'h000000, acc};
        `CCSE_REG_STATUS: s_axi_rdata <= {27'h0000000, !instrReady, badOp,
                                          lastSkip, negFlag, zeroFlag};
        default:          s_axi_rresp <= `CCSE_RESP_SLVERR;
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule : ccse_exec

// ### dv/ccse_exec_sva.sv
`include "ccse_params.svh"

module ccse_exec_sva (
  input wire logic        ref_clk,
  input wire logic        rstn,
  input wire logic [15:0] instrWord,
  input wire logic        instrValid,
  input wire logic        instrReady,
  input wire logic        nextTwoWord,
  input wire logic        flushNext,
  input wire logic        instrDone,
  input wire logic [11:0] memAddr,
  input wire logic        memRdEn,
  input wire logic [7:0]  memRdData,
  input wire logic        memWrEn,
  input wire logic [7:0]  memWrData
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  logic tk, cmp, cps;
  assign tk  = instrValid && instrReady;
  assign cmp = tk && instrWord[15:10] == `CCSE_COMP_OPC;
  assign cps = tk && instrWord[15:9] == `CCSE_CPSEQ_OPC;

  property p_done; cmp |-> ##5 instrDone; endproperty
  a_done: assert property (p_done) else $error("done late");
  property p_rd; cmp || cps |-> ##2 memRdEn ##1 !memRdEn; endproperty
  a_rd: assert property (p_rd) else $error("read slot");
  property p_busy; cmp || cps |=> !instrReady [*4]; endproperty
  a_busy: assert property (p_busy) else $error("ready early");
  property p_wr;
    cmp && instrWord[9] |-> ##5 memWrEn && memWrData == ~$past(memRdData, 2);
  endproperty
  a_wr: assert property (p_wr) else $error("bad writeback");
  property p_acc; cmp && !instrWord[9] |-> ##1 !memWrEn [*5]; endproperty
  a_acc: assert property (p_acc) else $error("stray write");
  property p_cmp; cps |-> ##1 !memWrEn [*5]; endproperty
  a_cmp: assert property (p_cmp) else $error("compare stored");
  property p_hi;
    (cmp || cps) && !instrWord[8] && instrWord[7:0] >= 8'h60
      |-> ##2 memAddr == {4'hf, $past(instrWord[7:0], 2)};
  endproperty
  a_hi: assert property (p_hi) else $error("access bank addr");
  property p_sk1; flushNext && !$past(nextTwoWord) |-> ##4 instrDone; endproperty
  a_sk1: assert property (p_sk1) else $error("one skip");
  property p_sk2;
    flushNext && $past(nextTwoWord) |-> !instrDone [*8] ##1 instrDone;
  endproperty
  a_sk2: assert property (p_sk2) else $error("two skips");

  c_sk1: cover property (flushNext && !$past(nextTwoWord));
  c_sk2: cover property (flushNext && $past(nextTwoWord));
  c_wr:  cover property (memWrEn);
endmodule : ccse_exec_sva

// ### dv/ccse_exec_test.sv
module ccse_exec_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic        ref_clk = 1'b0, rstn = 1'b0, instrValid = 1'b0;
  logic        nextTwoWord = 1'b0, s_axi_awvalid = 1'b0;
  logic        s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic        instrReady, flushNext, instrDone, memRdEn, memWrEn;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic        s_axi_arready, s_axi_rvalid;
  logic [15:0] instrWord = 16'h0;
  logic [11:0] memAddr, adr, ix;
  logic [7:0]  memRdData = 8'h0, memWrData, eAcc, f, dat, res;
  logic [3:0]  s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0;
  logic [3:0]  s_axi_wstrb = 4'hf, bk;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rdat;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rr, br;
  logic        eN, eZ, ex, a, d, two, eq, fl;
  logic [7:0]  mem [4096];
  int          errors = 0, comparisons = 0, cycles = 0, c;
  integer      seed = 32'h0e7e;

  ccse_exec u_ccse_exec (
    .ref_clk       (ref_clk),
    .rstn          (rstn),
    .instrWord     (instrWord),
    .instrValid    (instrValid),
    .instrReady    (instrReady),
    .nextTwoWord   (nextTwoWord),
    .flushNext     (flushNext),
    .instrDone     (instrDone),
    .memAddr       (memAddr),
    .memRdEn       (memRdEn),
    .memRdData     (memRdData),
    .memWrEn       (memWrEn),
    .memWrData     (memWrData),
    .s_axi_awaddr  (s_axi_awaddr),
    .s_axi_awvalid (s_axi_awvalid),
    .s_axi_awready (s_axi_awready),
    .s_axi_wdata   (s_axi_wdata),
    .s_axi_wstrb   (s_axi_wstrb),
    .s_axi_wvalid  (s_axi_wvalid),
    .s_axi_wready  (s_axi_wready),
    .s_axi_bresp   (s_axi_bresp),
    .s_axi_bvalid  (s_axi_bvalid),
    .s_axi_bready  (s_axi_bready),
    .s_axi_araddr  (s_axi_araddr),
    .s_axi_arvalid (s_axi_arvalid),
    .s_axi_arready (s_axi_arready),
    .s_axi_rdata   (s_axi_rdata),
    .s_axi_rresp   (s_axi_rresp),
    .s_axi_rvalid  (s_axi_rvalid),
    .s_axi_rready  (s_axi_rready)
  );

  always #5 ref_clk = ~ref_clk;

  // The byte is presented one cycle after the address, as the core expects.
  always @(posedge ref_clk) begin
    memRdData <= mem[memAddr];
    if (memWrEn) mem[memAddr] <= memWrData;
  end

  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 30000) begin
      errors++;
      end_sim();
    end
  end

  function automatic logic [11:0] ea(input logic ab, input logic [7:0] fa);
    if (ab) return {bk, fa};
    if (ex && fa <= 8'h5f) return ix + {4'h0, fa};
    return fa < 8'h60 ? {4'h0, fa} : {4'hf, fa};
  endfunction : ea

  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      errors++;
      $display("CHECK FAILED %s exp %h got %h", n, e, g);
    end
  endtask : chk

  task wr(input logic [3:0] ad, input logic [31:0] dw);
    @(posedge ref_clk);
    s_axi_awaddr  <= ad;
    s_axi_wdata   <= dw;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    br = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr

  task rd(input logic [3:0] ad);
    @(posedge ref_clk);
    s_axi_araddr  <= ad;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    rdat = s_axi_rdata;
    rr = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : rd

  task exec(input logic [15:0] w);
    c = 0;
    fl = 1'b0;
    @(posedge ref_clk);
    instrWord   <= w;
    instrValid  <= 1'b1;
    nextTwoWord <= two;
    @(posedge ref_clk);
    instrValid <= 1'b0;
    do begin
      @(posedge ref_clk);
      #1;
      c++;
      if (memRdEn === 1'b1) chk("memAddr", adr, memAddr);
      if (flushNext === 1'b1) fl = 1'b1;
    end while (instrDone !== 1'b1 && c < 20);
  endtask : exec

  task end_sim;
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : end_sim

  initial begin
    for (int k = 0; k < 4096; k++) mem[k] = 8'($random(seed));
    repeat (2) @(posedge ref_clk);
    rstn <= 1'b1;
    for (int k = 0; k < 4; k++) begin
      rd(4'(4 * k));
      chk("reset reg", 32'h0, rdat);
    end
    rd(4'h2);
    chk("unmapped resp", 2'h2, rr);
    wr(4'h1, 32'h0000_00ff);
    chk("misaligned resp", 2'h2, br);
    // An opcode outside both instructions must only raise the sticky bit.
    @(posedge ref_clk);
    instrWord  <= 16'hffff;
    instrValid <= 1'b1;
    @(posedge ref_clk);
    instrValid <= 1'b0;
    rd(4'hc);
    chk("badOp", 32'h8, rdat);
    wr(4'hc, 32'h8);
    rd(4'hc);
    chk("badOp clear", 32'h0, rdat);
    $display("registers test done");
    {eAcc, eN, eZ} = 10'h0;
    for (int i = 0; i < 48; i++) begin
      ex = 1'($random(seed));
      ix = 12'($random(seed));
      bk = 4'($random(seed));
      wr(4'h0, {12'h0, ix, 7'h0, ex});
      chk("bresp", 2'h0, br);
      wr(4'h4, {28'h0, bk});
      a = 1'($random(seed));
      two = 1'($random(seed));
      d = 1'($random(seed));
      f = (i % 3 == 0) ? 8'h5f + i[1] : 8'($random(seed));
      adr = ea(a, f);
      dat = mem[adr];
      res = ~dat;
      if (i % 2) begin
        if ($random(seed) & 1) begin
          wr(4'h8, {24'h0, dat});
          eAcc = dat;
        end
        eq = dat == eAcc;
        exec({7'h31, a, f});
        chk("skip", eq, fl);
        // Four clocks make one instruction cycle; c counts from the take.
        chk("cycles", 4 * (eq ? (two ? 3 : 2) : 1), c);
      end else begin
        exec({6'h07, d, a, f});
        chk("cycles", 4, c);
        if (!d) eAcc = res;
        eN = res[7];
        eZ = res == 8'h0;
      end
      rd(4'h8);
      chk("acc", eAcc, rdat);
      rd(4'hc);
      chk("flags", {eN, eZ}, rdat[1:0]);
      if (i % 2) chk("skipped", eq, rdat[2]);
      chk("mem", (i % 2 == 0 && d) ? res : dat, mem[adr]);
    end
    $display("execute test done");
    end_sim();
  end
endmodule : ccse_exec_test

bind ccse_exec ccse_exec_sva u_ccse_exec_sva (
  .ref_clk     (ref_clk),
  .rstn        (rstn),
  .instrWord   (instrWord),
  .instrValid  (instrValid),
  .instrReady  (instrReady),
  .nextTwoWord (nextTwoWord),
  .flushNext   (flushNext),
  .instrDone   (instrDone),
  .memAddr     (memAddr),
  .memRdEn     (memRdEn),
  .memRdData   (memRdData),
  .memWrEn     (memWrEn),
  .memWrData   (memWrData)
);
